// >>> core/bridge_if.sv
`timescale 1ns/1ps
`default_nettype none
// settings passed from the control core to one bridge sequencer
interface bridge_if;
  logic       en;        // bridge allowed to drive
  logic [5:0] dac;       // current code
  logic       phase;     // direction
  logic       slow;      // 1 slow decay, 0 mixed
  logic [4:0] off_code;  // off-time code
  logic [3:0] fd_code;   // fast decay code
  logic [1:0] blank;     // blank code
  logic [1:0] sr_mode;   // rectification mode
  logic       osc_tick;  // oscillator period enable
  modport ctrl (output en, dac, phase, slow, off_code, fd_code, blank,
                sr_mode, osc_tick);
  modport seq  (input en, dac, phase, slow, off_code, fd_code, blank,
                sr_mode, osc_tick);
endinterface
`default_nettype wire

// >>> core/bridge_seq.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_seq
  import chopper_pkg::*;
(
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  // settings
  bridge_if.seq      cfg,
  // comparator inputs
  input  wire logic  sense_trip,
  input  wire logic  zero_cross,
  // gate outputs
  output logic       hi_a,
  output logic       lo_a,
  output logic       hi_b,
  output logic       lo_b
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bridge_state_e state_r;          // chopper phase
  logic [8:0]    cnt_r;            // osc periods in phase
  logic          sr_off_r;         // rectifier dropped this off-time
  logic          phase_r;          // last phase seen
  logic [8:0]    off_len;          // off-time in osc periods
  logic [8:0]    fd_len;           // fast decay in osc periods
  logic [8:0]    blank_len;        // blank in osc periods
  logic          in_fast;          // fast decay portion active
  logic          blanked;          // comparator ignored
  logic          phase_chg;        // direction changed
  // t = (1+n)*8 - 1 oscillator periods
  assign off_len = 9'(({4'h0, cfg.off_code} + 9'h1) * OFF_STEP - 1);
  assign fd_len  = 9'(({5'h0, cfg.fd_code} + 9'h1) * OFF_STEP - 1);
  assign blank_len = (cfg.blank == 2'h0) ? 9'h004 :
                     (cfg.blank == 2'h1) ? 9'h006 :
                     (cfg.blank == 2'h2) ? 9'h008 : 9'h00c;
  assign phase_chg = (cfg.phase != phase_r);
  assign blanked   = (state_r == PH_ON) && (cnt_r < blank_len);
  // mixed: fast until fd count, fd beyond off gives all fast
  assign in_fast = !cfg.slow && (cnt_r < fd_len);
  // ------------------------------------------------------------
  // chopper sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r  <= PH_IDLE;
      cnt_r    <= 9'h000;
      sr_off_r <= 1'b0;
      phase_r  <= 1'b0;
    end else begin
      phase_r <= cfg.phase;
      if (!cfg.en) begin
        // disable command starts an off cycle in decay
        if (state_r == PH_ON) begin
          state_r <= PH_OFF;
          cnt_r   <= 9'h000;
        end else if (state_r == PH_OFF && cfg.osc_tick) begin
          cnt_r <= cnt_r + 9'h1;
          if (cnt_r >= off_len) state_r <= PH_IDLE;
        end
      end else if (state_r != PH_ON && (state_r == PH_IDLE ||
                   (cfg.osc_tick && cnt_r >= off_len))) begin
        state_r  <= PH_ON;
        cnt_r    <= 9'h000;
        sr_off_r <= 1'b0;
      end else if (state_r == PH_ON && phase_chg) begin
        cnt_r <= 9'h000;  // blank restarts on direction change
      end else if (state_r == PH_ON && !blanked && sense_trip) begin
        state_r  <= PH_OFF;
        cnt_r    <= 9'h000;
        sr_off_r <= 1'b0;
      end else if (cfg.osc_tick && cnt_r != 9'h1ff) begin
        cnt_r <= cnt_r + 9'h1;
      end
      // rectifier drop on zero current or reversed current at limit
      if (state_r == PH_OFF &&
          ((cfg.sr_mode == SR_ACTIVE && zero_cross) ||
           (cfg.sr_mode == SR_PASSIVE && sense_trip)))
        sr_off_r <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // gate decode
  // ------------------------------------------------------------
  logic on_ph, off_ph, sr_on, drive_a;
  assign on_ph  = (state_r == PH_ON) && cfg.en;
  assign off_ph = (state_r == PH_OFF);
  assign drive_a = cfg.phase;
  // rectification enabled unless dropped; disabled mode skips fast part
  assign sr_on = !sr_off_r && (cfg.sr_mode == SR_ACTIVE ||
                 cfg.sr_mode == SR_PASSIVE ||
                 (cfg.sr_mode == SR_DISABLED && !in_fast));
  always_comb begin
    hi_a = 1'b0;
    lo_a = 1'b0;
    hi_b = 1'b0;
    lo_b = 1'b0;
    if (on_ph) begin
      hi_a = drive_a;
      lo_b = drive_a;
      hi_b = !drive_a;
      lo_a = !drive_a;
    end else if (off_ph && sr_on) begin
      if (in_fast) begin
        // fast decay: reverse pair conducts
        hi_a = !drive_a;
        lo_b = !drive_a;
        hi_b = drive_a;
        lo_a = drive_a;
      end else begin
        // slow decay: both low sides
        lo_a = 1'b1;
        lo_b = 1'b1;
      end
    end
  end
  logic unused_dac;
  assign unused_dac = ^cfg.dac;
endmodule
`default_nettype wire

// >>> core/chopper_pkg.sv
package chopper_pkg;
  // ------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------
  localparam int WORD_W        = 19;  // bits per serial word
  localparam int SEL_POS       = 0;   // word selector position
  // word 0 fields
  localparam int DAC1_POS      = 1;
  localparam int DAC2_POS      = 7;
  localparam int DAC_W         = 6;
  localparam int PH1_POS       = 13;
  localparam int PH2_POS       = 14;
  localparam int MODE1_POS     = 15;
  localparam int MODE2_POS     = 16;
  localparam int REFSEL_POS    = 17;
  localparam int RANGE_POS     = 18;
  // word 1 fields
  localparam int BLANK_POS     = 1;
  localparam int OFF_POS       = 3;
  localparam int OFF_W         = 5;
  localparam int FD_POS        = 8;
  localparam int FD_W          = 4;
  localparam int OSC_POS       = 12;
  localparam int SR_POS        = 14;
  localparam int RUN_POS       = 18;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [18:0] WORD0_RST = 19'h00000;
  // off-time top bit set so the off-time is never too short
  localparam logic [18:0] WORD1_RST = 19'h00080;
  // ------------------------------------------------------------
  // encodings and timing
  // ------------------------------------------------------------
  localparam logic [1:0] OSC_INT  = 2'h0;
  localparam logic [1:0] OSC_DIV1 = 2'h1;
  localparam logic [1:0] OSC_DIV2 = 2'h2;
  localparam logic [1:0] OSC_DIV4 = 2'h3;
  localparam logic [1:0] SR_ACTIVE   = 2'h0;
  localparam logic [1:0] SR_DISABLED = 2'h1;
  localparam logic [1:0] SR_PASSIVE  = 2'h2;
  localparam int CLK_HZ        = 10_000_000;
  localparam int INT_OSC_HZ    = 4_000_000;
  // internal oscillator tick every this many ref clocks (rounded down)
  localparam int INT_OSC_DIV   = CLK_HZ / INT_OSC_HZ;
  localparam int OFF_STEP      = 8;   // oscillator periods per code step
  localparam int DAC_FULL      = 64;  // threshold denominator
  typedef enum logic [1:0] {PH_ON, PH_OFF, PH_IDLE} bridge_state_e;
endpackage

// >>> core/microstep_pwm_chopper_control.sv
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - sink gate supply fault disables all outputs
// - zero current code turns bridge off
// - threshold is (1+code)/64 of reference
// - range bit picks scaling of 4 or 8
// - mixed decay: fast first, then slow
// - fast longer than off-time means all fast
// - pwm timed by internal osc or external clock
// - osc field: internal, div1, div2, div4
// - low-power low disables outputs and pump
// - low-power resets config, off-time top bit set
// - thermal or supply faults disable while present
// - logic lockout disables drivers, resets config
// - overcurrent latches off until low-power toggles; logic lockout also clears it here
// - shorted load through sense does not latch
// - sense comparator blanked after bridge on
// - sense trip starts fixed off-time
// - off cycle on disable or off-time
// - active rectification stops at zero current
// - passive rectification stops at current limit
// - disabled rectification: low side in slow only
// - rectification field: active, disabled, passive
// - data shifted on rising serial clock
// - lowest bit selects word zero or one
//
module microstep_pwm_chopper_control
  import chopper_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // serial write port
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_frame,
  // power and timing pins
  input  wire logic        low_power_n,
  input  wire logic        ext_osc,
  // supply, thermal and overcurrent monitors
  input  wire logic        sink_gate_supply_fault,
  input  wire logic        gate_pump_supply_low,
  input  wire logic        thermal_fault,
  input  wire logic        logic_supply_lockout,
  input  wire logic        overcurrent_trip,
  // comparators
  input  wire logic        sense_trip1,
  input  wire logic        sense_trip2,
  input  wire logic        zero_cross1,
  input  wire logic        zero_cross2,
  // analog setpoints
  output logic [6:0]       thresh1,
  output logic [6:0]       thresh2,
  output logic             ref_external,
  output logic             range_div4,
  // power control
  output logic             pump_enable,
  output logic             reg_enable,
  // status
  output logic             ocp_latched,
  output logic             outputs_enabled,
  // gate drives
  output logic [3:0]       gates1,
  output logic [3:0]       gates2
);
  // ------------------------------------------------------------
  // serial shift path
  // ------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;     // incoming bits
  logic [WORD_W-1:0] word0_r;     // current and phase word
  logic [WORD_W-1:0] word1_r;     // timing and mode word
  logic              sclk_r;      // last serial clock sample
  logic              frame_r;     // last frame sample
  logic              lp_r;        // last low-power sample
  logic              cfg_clr;     // config reset condition
  logic              sclk_rise;
  logic              frame_rise;
  // pins are synchronous to ref_clk, so plain edge detect is enough
  assign sclk_rise  = ser_clk && !sclk_r;
  assign frame_rise = ser_frame && !frame_r;
  assign cfg_clr    = !low_power_n || logic_supply_lockout;
  // shift in msb first on each rising edge while framed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_r <= '0;
      sclk_r  <= 1'b0;
      frame_r <= 1'b1;
    end else begin
      sclk_r  <= ser_clk;
      frame_r <= ser_frame;
      if (cfg_clr)
        shift_r <= '0;
      else if (!ser_frame && sclk_rise)
        shift_r <= {shift_r[WORD_W-2:0], ser_data};
    end
  end
  // ------------------------------------------------------------
  // configuration words
  // ------------------------------------------------------------
  // only the last 19 bits of a longer frame are kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst || cfg_clr) begin
      word0_r <= WORD0_RST;
      word1_r <= WORD1_RST;
    end else if (frame_rise) begin
      if (shift_r[SEL_POS])
        word1_r <= shift_r;
      else
        word0_r <= shift_r;
    end
  end
  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic [DAC_W-1:0] dac1, dac2;
  logic [1:0]       osc_sel, sr_sel;
  logic             run_mode;
  assign dac1     = word0_r[DAC1_POS +: DAC_W];
  assign dac2     = word0_r[DAC2_POS +: DAC_W];
  assign osc_sel  = word1_r[OSC_POS +: 2];
  // reserved code 11 is treated as disabled rectification
  assign sr_sel   = (word1_r[SR_POS +: 2] == 2'h3) ? SR_DISABLED :
                    word1_r[SR_POS +: 2];
  assign run_mode = word1_r[RUN_POS];
  // threshold numerator over 64; zero code gives zero
  assign thresh1 = (dac1 == '0) ? 7'h00 : 7'({1'b0, dac1} + 7'h1);
  assign thresh2 = (dac2 == '0) ? 7'h00 : 7'({1'b0, dac2} + 7'h1);
  assign ref_external = word0_r[REFSEL_POS];
  assign range_div4   = word0_r[RANGE_POS];
  // ------------------------------------------------------------
  // oscillator source and divider
  // ------------------------------------------------------------
  logic [3:0] int_cnt_r;   // internal tick divider
  logic [1:0] ext_cnt_r;   // external edge divider
  logic       ext_r;       // last external clock sample
  logic       ext_rise;
  logic       ext_tick;
  logic       int_tick;
  logic       osc_tick;
  assign ext_rise = ext_osc && !ext_r;
  assign int_tick = (int_cnt_r == 4'(INT_OSC_DIV - 1));
  assign ext_tick = ext_rise && ((osc_sel == OSC_DIV1) ||
                    (osc_sel == OSC_DIV2 && ext_cnt_r[0]) ||
                    (osc_sel == OSC_DIV4 && ext_cnt_r == 2'h3));
  assign osc_tick = (osc_sel == OSC_INT) ? int_tick : ext_tick;
  // internal tick is a 5 MHz rate from the 10 MHz clock, every 2 ref clocks
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_cnt_r <= 4'h0;
      ext_cnt_r <= 2'h0;
      ext_r     <= 1'b0;
    end else begin
      ext_r     <= ext_osc;
      int_cnt_r <= int_tick ? 4'h0 : int_cnt_r + 4'h1;
      if (ext_rise)
        ext_cnt_r <= ext_cnt_r + 2'h1;
    end
  end
  // ------------------------------------------------------------
  // faults and enables
  // ------------------------------------------------------------
  logic ocp_r;      // overcurrent latch
  logic drv_ok;     // all outputs allowed
  // latch held until low-power input toggles or logic lockout, cleared on the pin's rising edge or by lockout
  always_ff @(posedge ref_clk) begin
    if (sys_rst || logic_supply_lockout) begin
      ocp_r <= 1'b0;
      // idle level of the pin, so no false wake edge follows reset
      lp_r  <= 1'b1;
    end else begin
      lp_r <= low_power_n;
      if (overcurrent_trip)
        ocp_r <= 1'b1;
      else if (low_power_n && !lp_r)
        ocp_r <= 1'b0;
    end
  end
  // non-latched faults gate the drive only while present
  assign drv_ok = low_power_n && run_mode && !logic_supply_lockout &&
                  !sink_gate_supply_fault &&
                  !gate_pump_supply_low && !thermal_fault &&
                  !ocp_r;
  assign pump_enable     = low_power_n && run_mode;
  assign reg_enable      = low_power_n;
  assign ocp_latched     = ocp_r;
  assign outputs_enabled = drv_ok;
  // ------------------------------------------------------------
  // bridge sequencers
  // ------------------------------------------------------------
  bridge_if b1 ();
  bridge_if b2 ();
  logic [3:0] raw1, raw2;
  assign b1.en       = (dac1 != '0) && drv_ok;
  assign b2.en       = (dac2 != '0) && drv_ok;
  assign b1.dac      = dac1;
  assign b2.dac      = dac2;
  assign b1.phase    = word0_r[PH1_POS];
  assign b2.phase    = word0_r[PH2_POS];
  assign b1.slow     = word0_r[MODE1_POS];
  assign b2.slow     = word0_r[MODE2_POS];
  assign b1.off_code = word1_r[OFF_POS +: OFF_W];
  assign b2.off_code = word1_r[OFF_POS +: OFF_W];
  assign b1.fd_code  = word1_r[FD_POS +: FD_W];
  assign b2.fd_code  = word1_r[FD_POS +: FD_W];
  assign b1.blank    = word1_r[BLANK_POS +: 2];
  assign b2.blank    = word1_r[BLANK_POS +: 2];
  assign b1.sr_mode  = sr_sel;
  assign b2.sr_mode  = sr_sel;
  assign b1.osc_tick = osc_tick;
  assign b2.osc_tick = osc_tick;
  bridge_seq u_seq1 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .cfg        (b1),
    .sense_trip (sense_trip1),
    .zero_cross (zero_cross1),
    .hi_a       (raw1[3]),
    .lo_a       (raw1[2]),
    .hi_b       (raw1[1]),
    .lo_b       (raw1[0])
  );
  bridge_seq u_seq2 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .cfg        (b2),
    .sense_trip (sense_trip2),
    .zero_cross (zero_cross2),
    .hi_a       (raw2[3]),
    .lo_a       (raw2[2]),
    .hi_b       (raw2[1]),
    .lo_b       (raw2[0])
  );
  // ------------------------------------------------------------
  // gate output registers
  // ------------------------------------------------------------
  // faults force every driver off, decay included
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gates1 <= 4'h0;
      gates2 <= 4'h0;
    end else begin
      // a zero code turns the whole bridge off, decay included
      gates1 <= b1.en ? raw1 : 4'h0;
      gates2 <= b2.en ? raw2 : 4'h0;
    end
  end
  // wake settling time is left to the controller
endmodule
`default_nettype wire

// >>> tb/chopper_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the chopper control block
// ------------------------------------------------------------
module chopper_monitor (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // power and fault inputs
  input wire logic       low_power_n,
  input wire logic       sink_gate_supply_fault,
  input wire logic       gate_pump_supply_low,
  input wire logic       thermal_fault,
  input wire logic       logic_supply_lockout,
  input wire logic       overcurrent_trip,
  // observed outputs
  input wire logic [6:0] thresh1,
  input wire logic       pump_enable,
  input wire logic       reg_enable,
  input wire logic       ocp_latched,
  input wire logic       outputs_enabled,
  input wire logic [3:0] gates1,
  input wire logic [3:0] gates2
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // three cycles leave room for the registered gate stage
  sequence fault_held;
    (thermal_fault || gate_pump_supply_low || sink_gate_supply_fault)[*3];
  endsequence
  // latch seen with wake and logic supply steady
  sequence latch_kept;
    (ocp_latched && low_power_n && !logic_supply_lockout)[*3];
  endsequence
  sink_fault_off_a : assert property (
    sink_gate_supply_fault |-> !outputs_enabled)
    else $error("drive allowed during sink supply fault");
  fault_gates_a : assert property (
    fault_held |-> gates1 == 4'h0 && gates2 == 4'h0)
    else $error("gates on during supply or thermal fault");
  sleep_off_a : assert property (
    !low_power_n |-> !outputs_enabled && !pump_enable && !reg_enable)
    else $error("power stages on while asleep");
  zero_code_a : assert property (
    (thresh1 == 7'h00)[*3] |-> gates1 == 4'h0)
    else $error("bridge driven with zero code");
  thresh_code_a : assert property (
    thresh1 != 7'h01)
    else $error("threshold value not reachable from any code");
  ocp_set_a : assert property (
    overcurrent_trip && low_power_n |=> ocp_latched)
    else $error("overcurrent did not latch");
  ocp_hold_a : assert property (
    latch_kept |=> ocp_latched)
    else $error("overcurrent latch dropped by itself");
  ocp_off_a : assert property (
    ocp_latched |-> !outputs_enabled)
    else $error("drive allowed while latched");
  lockout_a : assert property (
    logic_supply_lockout && !overcurrent_trip |=> !ocp_latched
      && !outputs_enabled)
    else $error("lockout did not clear and disable");
endmodule
`default_nettype wire

// >>> tb/microstep_pwm_chopper_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module microstep_pwm_chopper_control_bench;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic ref_clk = 1'b0, sys_rst = 1'b1, low_power_n = 1'b1, ext_osc = 1'b0;
  logic sink_gate_supply_fault = 1'b0, gate_pump_supply_low = 1'b0;
  logic thermal_fault = 1'b0, logic_supply_lockout = 1'b0;
  logic overcurrent_trip = 1'b0, sense_trip1 = 1'b0, sense_trip2 = 1'b0;
  logic zero_cross1 = 1'b0, zero_cross2 = 1'b0;
  wire  ser_clk, ser_data, ser_frame;
  logic [6:0] thresh1, thresh2;
  logic ref_external, range_div4, pump_enable, reg_enable;
  logic ocp_latched, outputs_enabled;
  logic [3:0] gates1, gates2;
  logic [31:0] seed = 32'h6831af67;
  logic [31:0] r;
  logic [5:0]  c1, c2;
  int err_count = 0, compares = 0;
  always #50 ref_clk = ~ref_clk;
  microstep_pwm_chopper_control microstep_pwm_chopper_control_inst (
    .ref_clk, .sys_rst, .ser_clk, .ser_data, .ser_frame, .low_power_n,
    .ext_osc, .sink_gate_supply_fault, .gate_pump_supply_low,
    .thermal_fault, .logic_supply_lockout, .overcurrent_trip,
    .sense_trip1, .sense_trip2, .zero_cross1, .zero_cross2, .thresh1,
    .thresh2, .ref_external, .range_div4, .pump_enable, .reg_enable,
    .ocp_latched, .outputs_enabled, .gates1, .gates2);
  ser_master ser_master_inst (.ref_clk, .ser_clk, .ser_data, .ser_frame);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // top = range, ref, mode2, mode1, phase2, phase1
  function automatic logic [18:0] w0(logic [5:0] top, c2, c1);
    return {top, c2, c1, 1'b0};
  endfunction
  // run bit set, reserved bits zero, fast decay and blank codes zero
  function automatic logic [18:0] w1(logic [1:0] osc, sr, logic [4:0] off);
    return {1'b1, 2'h0, sr, osc, 4'h0, off, 2'h0, 1'b1};
  endfunction
  function automatic logic [6:0] exp_thr(logic [5:0] c);
    return (c == 6'h00) ? 7'h00 : {1'b0, c} + 7'h01;
  endfunction
  task automatic note(input logic [6:0] g, input logic [6:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_thr(input logic [6:0] g, e); note(g, e); endtask
  task automatic chk_bit(input logic g, e); note({6'h0, g}, {6'h0, e}); endtask
  task automatic chk_gate(input logic [3:0] g, e); note({3'h0, g}, {3'h0, e});
  endtask
  // bounded wait for a gate pattern on bridge one
  task automatic wait_g1(input logic [3:0] e);
    for (int n = 0; n < 1000 && gates1 !== e; n++) @(negedge ref_clk);
    chk_gate(gates1, e);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic complete_run();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // random comparator noise and an external timing clock
  // own draw, so the main sequence keeps its r across edges
  always @(posedge ref_clk) begin
    logic [31:0] q;
    q = rnd();
    zero_cross1 <= q[0];
    zero_cross2 <= q[1];
    if (q[2]) ext_osc <= ~ext_osc;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cycles(2);
    chk_thr(thresh1, 7'h00);
    chk_bit(pump_enable, 1'b0);
    // random current words with corner codes
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      c1 = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : r[5:0];
      c2 = (k == 0) ? 6'h01 : r[11:6];
      ser_master_inst.hold = 2 + int'(r[12]);
      ser_master_inst.send_word(w0(r[18:13], c2, c1));
      @(negedge ref_clk);
      chk_thr(thresh1, exp_thr(c1));
      chk_thr(thresh2, exp_thr(c2));
      chk_bit(range_div4, r[18]);
      chk_bit(ref_external, r[17]);
    end
    // timing word must not touch the current settings
    ser_master_inst.send_word(w1(2'h0, 2'h1, 5'h00));
    @(negedge ref_clk);
    chk_thr(thresh1, exp_thr(c1));
    chk_bit(pump_enable, 1'b1);
    chk_bit(outputs_enabled, 1'b1);
    // bridge one slow decay, phase high; bridge two phase low
    ser_master_inst.send_word(w0(6'h05, 6'h09, 6'h05));
    wait_g1(4'h9);
    chk_gate(gates2, 4'h6);
    // trip, off-time and blanking for each source and rectifier mode
    for (int i = 0; i < 4; i++) begin
      ser_master_inst.send_word(w1(2'(i), 2'(i), 5'h00));
      sense_trip1 <= 1'b1;
      for (int n = 0; n < 1000 && gates1 === 4'h9; n++) @(negedge ref_clk);
      @(posedge ref_clk);
      sense_trip1 <= 1'b0;
      @(negedge ref_clk);
      chk_bit(gates1 !== 4'h9, 1'b1);
      if (i == 1) chk_gate(gates1, 4'h5);
      wait_g1(4'h9);
      @(posedge ref_clk);
      sense_trip1 <= 1'b1;
      cycles(2);
      chk_gate(gates1, 4'h9);
      @(posedge ref_clk);
      sense_trip1 <= 1'b0;
      wait_g1(4'h9);
    end
    // each supply or thermal fault disables, then drive resumes
    for (int f = 0; f < 3; f++) begin
      @(posedge ref_clk);
      {thermal_fault, gate_pump_supply_low, sink_gate_supply_fault} <= 3'(1 << f);
      cycles(4);
      chk_bit(outputs_enabled, 1'b0);
      chk_gate(gates1, 4'h0);
      @(posedge ref_clk);
      {thermal_fault, gate_pump_supply_low, sink_gate_supply_fault} <= 3'h0;
      wait_g1(4'h9);
    end
    // overcurrent pulse latches until a sleep cycle
    @(posedge ref_clk);
    overcurrent_trip <= 1'b1;
    @(posedge ref_clk);
    overcurrent_trip <= 1'b0;
    cycles(12);
    chk_bit(ocp_latched, 1'b1);
    chk_gate(gates1, 4'h0);
    @(posedge ref_clk);
    low_power_n <= 1'b0;
    cycles(3);
    chk_bit(reg_enable, 1'b0);
    chk_thr(thresh1, 7'h00);
    @(posedge ref_clk);
    low_power_n <= 1'b1;
    cycles(3);
    chk_bit(ocp_latched, 1'b0);
    chk_bit(pump_enable, 1'b0);
    repeat (10000) @(posedge ref_clk);
    ser_master_inst.send_word(w0(6'h00, 6'h3e, 6'h01));
    @(negedge ref_clk);
    chk_thr(thresh2, 7'h3f);
    // logic supply lockout clears the settings
    @(posedge ref_clk);
    logic_supply_lockout <= 1'b1;
    cycles(3);
    chk_thr(thresh2, 7'h00);
    chk_bit(outputs_enabled, 1'b0);
    @(posedge ref_clk);
    logic_supply_lockout <= 1'b0;
    cycles(2);
    complete_run();
  end
endmodule
bind microstep_pwm_chopper_control chopper_monitor chopper_monitor_inst (
  .ref_clk, .sys_rst, .low_power_n, .sink_gate_supply_fault,
  .gate_pump_supply_low, .thermal_fault, .logic_supply_lockout,
  .overcurrent_trip, .thresh1, .pump_enable, .reg_enable, .ocp_latched,
  .outputs_enabled, .gates1, .gates2);
`default_nettype wire

// >>> tb/ser_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// external controller writing the serial port
// ------------------------------------------------------------
module ser_master (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic     ser_clk,
  output logic     ser_data,
  output logic     ser_frame
);
  int hold = 2;  // ref clocks per level; 1 is the fastest the port takes
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_frame = 1'b1;
  end
  // one whole word, frame low only while shifting
  task automatic send_word(input logic [18:0] w);
    @(posedge ref_clk);
    ser_frame <= 1'b0;
    for (int i = 18; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (hold) @(posedge ref_clk);
      ser_clk <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      ser_clk <= 1'b0;
    end
    repeat (hold) @(posedge ref_clk);
    ser_frame <= 1'b1;
    // no pull on data: show the inverse rather than a stale bit
    ser_data <= ~w[0];
    repeat (hold + 2) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire
